// ---- rtl/cmp_pkg.sv ----
package cmp_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned UNITS = 2;
  localparam int unsigned CW    = 16;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] UNIT_STRIDE = 8'h10;
  localparam logic [7:0] FIELD_CTRL  = 8'h00;
  localparam logic [7:0] FIELD_LO    = 8'h04;
  localparam logic [7:0] FIELD_HI    = 8'h08;
  localparam logic [7:0] ALT_OFF     = 8'h20;
  localparam logic [7:0] STAT_OFF    = 8'h24;
  localparam logic [7:0] MASK_OFF    = 8'h28;
  localparam logic [7:0] PINST_OFF   = 8'h2c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned DUTY_LSB   = 4;
  localparam int unsigned ROUTE_BIT  = 0;
  localparam int unsigned SPARE_BIT  = 1;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [CW-1:0] MATCH_RST = 16'h0000;
  localparam logic [1:0]  HTRANS_NSQ = 2'h2;

  // ----------------------------------------------------------------------
  // Mode field encodings for compare operation
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SWINT   = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;

  // Index of the unit that may start a conversion.
  localparam int unsigned ADC_UNIT = 1;

endpackage : cmp_pkg

// ---- rtl/compare_unit.sv ----
module compare_unit
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Configuration
  input  wire logic [3:0]    mode_i,
  input  wire logic          ctrl_clear_i,
  input  wire logic [CW-1:0] match_value_i,
  // Timer and power state
  input  wire logic [CW-1:0] count_i,
  input  wire logic          asleep_i,
  // Results
  output logic               match_evt_o,
  output logic               pin_latch_o,
  output logic               pin_drive_o,
  output logic               clear_req_o,
  output logic               trig_evt_o
);

  logic equal;
  logic equal_d;
  logic cmp_mode;
  logic hit;

  // --------------------------------------------------------------------
  // Match detection
  // --------------------------------------------------------------------
  // Equality is tested every cycle; an action fires once per new match.
  assign equal    = (match_value_i == count_i);
  assign cmp_mode = (mode_i == MODE_TOGGLE) || (mode_i == MODE_SET) ||
                    (mode_i == MODE_CLEAR) || (mode_i == MODE_SWINT) ||
                    (mode_i == MODE_SPECIAL);
  // Without the system clock no action is guaranteed, so sleep masks it.
  assign hit = cmp_mode && equal && !equal_d && !asleep_i;

  // Previous equality, used to fire once per match.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      equal_d <= 1'b0;
    end else begin
      equal_d <= equal;
    end
  end

  // Every compare mode raises the match event.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      match_evt_o <= 1'b0;
    end else begin
      match_evt_o <= hit;
    end
  end

  // --------------------------------------------------------------------
  // Compare output latch and pin ownership
  // --------------------------------------------------------------------
  // The latch is forced low by a full control clear, else follows mode.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_latch_o <= 1'b0;
    end else if (ctrl_clear_i) begin
      pin_latch_o <= 1'b0;
    end else if (hit) begin
      case (mode_i)
        MODE_TOGGLE: pin_latch_o <= !pin_latch_o;
        MODE_SET:    pin_latch_o <= 1'b1;
        MODE_CLEAR:  pin_latch_o <= 1'b0;
        default:     pin_latch_o <= pin_latch_o;
      endcase
    end
  end

  // Only the pin-action modes take the pin; event modes leave it to the port.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_drive_o <= 1'b0;
    end else begin
      pin_drive_o <= (mode_i == MODE_TOGGLE) || (mode_i == MODE_SET) ||
                     (mode_i == MODE_CLEAR);
    end
  end

  // --------------------------------------------------------------------
  // Special event
  // --------------------------------------------------------------------
  // The clear request stands only while equality holds, so rewriting the
  // match value before the timer edge withdraws it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_req_o <= 1'b0;
      trig_evt_o  <= 1'b0;
    end else begin
      clear_req_o <= (mode_i == MODE_SPECIAL) && equal && !asleep_i;
      trig_evt_o  <= hit && (mode_i == MODE_SPECIAL);
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_match_flag;
    @(posedge clk_i) disable iff (rst_i)
    (cmp_mode && equal && !equal_d && !asleep_i) |=> match_evt_o;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match event missing after new match");

  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
    (hit && mode_i == MODE_TOGGLE && !ctrl_clear_i) |=>
      (pin_latch_o != $past(pin_latch_o));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle mode did not invert latch");

  property p_set_clear;
    @(posedge clk_i) disable iff (rst_i)
    (hit && !ctrl_clear_i && (mode_i == MODE_SET || mode_i == MODE_CLEAR)) |=>
      (pin_latch_o == ($past(mode_i) == MODE_SET));
  endproperty
  a_set_clear: assert property (p_set_clear)
    else $error("set or clear mode left wrong latch level");

  property p_event_no_pin;
    @(posedge clk_i) disable iff (rst_i)
    (mode_i == MODE_SWINT || mode_i == MODE_SPECIAL) |=> !pin_drive_o;
  endproperty
  a_event_no_pin: assert property (p_event_no_pin)
    else $error("event mode took the pin");

  property p_cancel;
    @(posedge clk_i) disable iff (rst_i)
    (clear_req_o && !equal) |=> !clear_req_o;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("timer clear not withdrawn after match lost");

  property p_ctrl_clear;
    @(posedge clk_i) disable iff (rst_i)
    ctrl_clear_i |=> (!pin_latch_o && !match_evt_o) [*2];
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear)
    else $error("full control clear did not force latch low");

endmodule // compare_unit

// ---- rtl/compare_match_top.sv ----
module compare_match_top
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic                 MCLK_I,
  input  wire logic                 SYS_RST_I,
  // AHB-Lite slave
  input  wire logic                 HSEL_I,
  input  wire logic [31:0]          HADDR_I,
  input  wire logic [1:0]           HTRANS_I,
  input  wire logic                 HWRITE_I,
  input  wire logic [2:0]           HSIZE_I,
  input  wire logic [31:0]          HWDATA_I,
  input  wire logic                 HREADY_I,
  output logic      [31:0]          HRDATA_O,
  output logic                      HREADYOUT_O,
  output logic                      HRESP_O,
  // Timer and converter side
  input  wire logic [cmp_pkg::CW-1:0] TIMER1_COUNT_I,
  input  wire logic                 ADC_ENABLE_I,
  input  wire logic                 SLEEP_I,
  output logic                      TIMER1_CLEAR_O,
  output logic                      ADC_START_O,
  // Pins
  output logic                      UNIT1_PIN_O,
  output logic                      UNIT1_PIN_OE_O,
  output logic                      PORT_C_LINE1_O,
  output logic                      PORT_C_LINE1_OE_O,
  output logic                      PORT_B_LINE3_O,
  output logic                      PORT_B_LINE3_OE_O,
  // Interrupt
  output logic                      IRQ_O
);

  logic [3:0]    mode       [UNITS];
  logic [1:0]    duty       [UNITS];
  logic [CW-1:0] match_value[UNITS];
  logic          ctrl_clear [UNITS];
  logic [UNITS-1:0] match_evt;
  logic [UNITS-1:0] pin_latch;
  logic [UNITS-1:0] pin_drive;
  logic [UNITS-1:0] clear_req;
  logic [UNITS-1:0] trig_evt;
  logic          route_sel;
  logic          spare_sel;
  logic [UNITS-1:0] status;
  logic [UNITS-1:0] mask;
  logic [UNITS-1:0] next_status;
  logic          dp_wr;
  logic [7:0]    dp_addr;
  logic          accept;
  logic          mapped;
  logic          rd_stat;
  logic [31:0]   next_rdata;

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  // A transfer is taken when selected, ready and NONSEQ or SEQ (HTRANS_I[1] set).
  assign accept  = HSEL_I && HREADY_I && HTRANS_I[1];
  assign mapped  = (HADDR_I[31:8] == 24'h000000);
  assign rd_stat = accept && !HWRITE_I && mapped && (HADDR_I[7:0] == STAT_OFF);

  // Latch the write address for the data phase.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= accept && HWRITE_I && mapped;
      dp_addr <= HADDR_I[7:0];
    end
  end

  // Always ready with an OKAY answer.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 32'h00000000;
    if (mapped) begin
      for (int u = 0; u < UNITS; u++) begin
        if (HADDR_I[7:0] == 8'(u * UNIT_STRIDE) + FIELD_CTRL) begin
          next_rdata[7:0] = {2'h0, duty[u], mode[u]};
        end
        if (HADDR_I[7:0] == 8'(u * UNIT_STRIDE) + FIELD_LO) begin
          next_rdata[7:0] = match_value[u][7:0];
        end
        if (HADDR_I[7:0] == 8'(u * UNIT_STRIDE) + FIELD_HI) begin
          next_rdata[7:0] = match_value[u][15:8];
        end
      end
      case (HADDR_I[7:0])
        ALT_OFF:   next_rdata[1:0] = {spare_sel, route_sel};
        STAT_OFF:  next_rdata[UNITS-1:0] = status;
        MASK_OFF:  next_rdata[UNITS-1:0] = mask;
        PINST_OFF: next_rdata[UNITS-1:0] = pin_latch;
        default:   next_rdata = next_rdata;
      endcase
    end
  end

  // Read data is registered at the address phase, valid in the data phase.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (accept && !HWRITE_I) begin
      HRDATA_O <= next_rdata;
    end else begin
      HRDATA_O <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Unit registers
  // ----------------------------------------------------------------------
  // Control and match registers, written in the data phase.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      for (int u = 0; u < UNITS; u++) begin
        mode[u]        <= CTRL_RST[MODE_LSB +: 4];
        duty[u]        <= CTRL_RST[DUTY_LSB +: 2];
        match_value[u] <= MATCH_RST;
        ctrl_clear[u]  <= 1'b0;
      end
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        ctrl_clear[u] <= 1'b0;
        if (dp_wr && dp_addr == 8'(u * UNIT_STRIDE) + FIELD_CTRL) begin
          mode[u]       <= HWDATA_I[MODE_LSB +: 4];
          duty[u]       <= HWDATA_I[DUTY_LSB +: 2];
          ctrl_clear[u] <= (HWDATA_I[7:0] == 8'h00);
        end
        if (dp_wr && dp_addr == 8'(u * UNIT_STRIDE) + FIELD_LO) begin
          match_value[u][7:0] <= HWDATA_I[7:0];
        end
        if (dp_wr && dp_addr == 8'(u * UNIT_STRIDE) + FIELD_HI) begin
          match_value[u][15:8] <= HWDATA_I[7:0];
        end
      end
    end
  end

  // Alternate pin select and interrupt mask.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      route_sel <= 1'b0;
      spare_sel <= 1'b0;
      mask      <= '0;
    end else begin
      if (dp_wr && dp_addr == ALT_OFF) begin
        route_sel <= HWDATA_I[ROUTE_BIT];
        spare_sel <= HWDATA_I[SPARE_BIT];
      end
      if (dp_wr && dp_addr == MASK_OFF) begin
        mask <= HWDATA_I[UNITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Compare units
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < UNITS; g++) begin : g_unit
    compare_unit u_cmp (
      .clk_i        (MCLK_I),
      .rst_i        (SYS_RST_I),
      .mode_i       (mode[g]),
      .ctrl_clear_i (ctrl_clear[g]),
      .match_value_i(match_value[g]),
      .count_i      (TIMER1_COUNT_I),
      .asleep_i     (SLEEP_I),
      .match_evt_o  (match_evt[g]),
      .pin_latch_o  (pin_latch[g]),
      .pin_drive_o  (pin_drive[g]),
      .clear_req_o  (clear_req[g]),
      .trig_evt_o   (trig_evt[g])
    );
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Sticky match flags; a status read clears them but a new match wins.
  assign next_status = (rd_stat ? '0 : status) | match_evt;

  // Status flags and the level interrupt.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      status <= '0;
      IRQ_O  <= 1'b0;
    end else begin
      status <= next_status;
      IRQ_O  <= |(next_status & mask);
    end
  end

  // ----------------------------------------------------------------------
  // Timer and converter outputs
  // ----------------------------------------------------------------------
  // The clear request is a plain synchronous clear, kept apart from the
  // counter's wrap path, so it never raises the overflow flag.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      TIMER1_CLEAR_O <= 1'b0;
      ADC_START_O    <= 1'b0;
    end else begin
      TIMER1_CLEAR_O <= |clear_req;
      ADC_START_O    <= trig_evt[ADC_UNIT] && ADC_ENABLE_I;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  // The second unit drives only the port pin chosen by the route select.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      UNIT1_PIN_O       <= 1'b0;
      UNIT1_PIN_OE_O    <= 1'b0;
      PORT_C_LINE1_O    <= 1'b0;
      PORT_C_LINE1_OE_O <= 1'b0;
      PORT_B_LINE3_O    <= 1'b0;
      PORT_B_LINE3_OE_O <= 1'b0;
    end else begin
      UNIT1_PIN_O       <= pin_latch[0];
      UNIT1_PIN_OE_O    <= pin_drive[0];
      PORT_C_LINE1_O    <= pin_latch[1];
      PORT_C_LINE1_OE_O <= pin_drive[1] && !route_sel;
      PORT_B_LINE3_O    <= pin_latch[1];
      PORT_B_LINE3_OE_O <= pin_drive[1] && route_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_special_match;
    trig_evt[ADC_UNIT] && ADC_ENABLE_I;
  endsequence

  property p_adc_start;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
    s_special_match |=> ADC_START_O;
  endproperty
  a_adc_start: assert property (p_adc_start)
    else $error("conversion start missing after special event");

  property p_clear_follows;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
    (|clear_req) |=> TIMER1_CLEAR_O;
  endproperty
  a_clear_follows: assert property (p_clear_follows)
    else $error("timer clear request not forwarded");

  property p_sleep;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
    (SLEEP_I ##1 SLEEP_I) |=> (!TIMER1_CLEAR_O && !ADC_START_O);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("compare action while asleep");

  property p_route;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
    1'b1 |=> !(PORT_C_LINE1_OE_O && PORT_B_LINE3_OE_O) &&
             (PORT_B_LINE3_OE_O == ($past(pin_drive[1]) && $past(route_sel)));
  endproperty
  a_route: assert property (p_route)
    else $error("second unit pin routed wrongly");

  property p_irq;
    @(posedge MCLK_I) disable iff (SYS_RST_I)
    ((|(status & mask)) && $stable(mask)) |-> IRQ_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt low with unmasked flag set");

endmodule // compare_match_top

// ---- tb/timer1_model.sv ----
module timer1_model
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Bench control
  input  wire logic          run_i,
  input  wire logic          load_i,
  input  wire logic [CW-1:0] load_val_i,
  // Block side
  input  wire logic          clear_i,
  input  wire logic          adc_en_i,
  input  wire logic          start_i,
  output logic      [CW-1:0] count_o,
  output logic               ovf_o,
  output int                 starts_o
);
  logic [1:0] pre;

  // Count ticks every fourth system clock, in step with the system clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre <= 2'h0;
      count_o <= 16'h0000;
      ovf_o <= 1'b0;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (run_i) begin
      pre <= pre + 2'h1;
      if (pre == 2'h3 && clear_i) begin
        count_o <= 16'h0000;
      end else if (pre == 2'h3) begin
        count_o <= count_o + 16'h0001;
        ovf_o <= ovf_o | (count_o == 16'hffff);
      end
    end
  end

  // The converter starts only while it is enabled.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      starts_o <= 0;
    end else if (start_i && adc_en_i) begin
      starts_o <= starts_o + 1;
    end
  end
endmodule // timer1_model

// ---- tb/tb_timer_compare_match_unit.sv ----
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module tb_timer_compare_match_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_pkg::*;

  logic        mclk, rst, hsel, hwrite, hrdy, hresp, run, load, adc_en, sleep;
  logic        clr, start, p1, p1_oe, pc, pc_oe, pb, pb_oe, irq, ovf;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cnt, ld_val;
  int          starts, s0, mismatches, n_compared;

  // ----------------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------------
  compare_match_top dut_u (.MCLK_I(mclk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .TIMER1_COUNT_I(cnt), .ADC_ENABLE_I(adc_en), .SLEEP_I(sleep),
    .TIMER1_CLEAR_O(clr), .ADC_START_O(start), .UNIT1_PIN_O(p1), .UNIT1_PIN_OE_O(p1_oe),
    .PORT_C_LINE1_O(pc), .PORT_C_LINE1_OE_O(pc_oe), .PORT_B_LINE3_O(pb),
    .PORT_B_LINE3_OE_O(pb_oe), .IRQ_O(irq));

  timer1_model u_timer (.clk_i(mclk), .rst_i(rst), .run_i(run), .load_i(load),
    .load_val_i(ld_val), .clear_i(clr), .adc_en_i(adc_en), .start_i(start),
    .count_o(cnt), .ovf_o(ovf), .starts_o(starts));

  // ----------------------------------------------------------------------
  // Bus and timer helpers
  // ----------------------------------------------------------------------
  // Waits until ready is sampled high at a rising edge; the watchdog bounds it.
  task automatic wait_rdy();
    do begin
      @(posedge mclk);
    end while (hrdy !== 1'b1);
  endtask

  // One single transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NSQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK("register read", ex, rd)
  endtask

  // Moves the count away from v and back onto it, then lets the result land.
  task automatic hit(input logic [15:0] v);
    load <= 1'b1;
    ld_val <= ~v;
    @(posedge mclk);
    ld_val <= v;
    @(posedge mclk);
    load <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values of unit 1 control and match, unit 2 control, alternate select, mask and an unmapped word.
  task automatic t_regs();
    logic [7:0] offs [7];
    offs = '{FIELD_CTRL, FIELD_LO, FIELD_HI, UNIT_STRIDE, ALT_OFF, MASK_OFF, 8'h40};
    foreach (offs[i]) rdchk(offs[i], 32'h0);
    `CHK("bus response", 1'b0, hresp)
    `CHK("bus ready", 1'b1, hrdy)
  endtask

  // Set, clear and two toggles on unit 1, then a zero control write.
  task automatic t_pin();
    logic [3:0] m [4];
    logic [3:0] ex;
    m = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_TOGGLE};
    ex = 4'ha;
    bus(1'b1, FIELD_LO, 32'h10);
    foreach (m[i]) begin
      bus(1'b1, FIELD_CTRL, {28'h0, m[i]});
      hit(16'h0010);
      `CHK("unit1 pin", ex[3-i], p1)
      `CHK("unit1 enable", 1'b1, p1_oe)
    end
    rdchk(STAT_OFF, 32'h1);
    bus(1'b1, FIELD_CTRL, {28'h0, MODE_SET});
    hit(16'h0010);
    `CHK("latch before zero", 1'b1, p1)
    bus(1'b1, FIELD_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK("latch after zero", 1'b0, p1)
  endtask

  // Software interrupt mode, masking, flag clearing and sleep.
  task automatic t_swint();
    bus(1'b1, MASK_OFF, 32'h1);
    bus(1'b1, FIELD_CTRL, {28'h0, MODE_SWINT});
    hit(16'h0010);
    `CHK("pin released", 1'b0, p1_oe)
    `CHK("irq raised", 1'b1, irq)
    rdchk(STAT_OFF, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    sleep <= 1'b1;
    hit(16'h0010);
    rdchk(STAT_OFF, 32'h0);
    sleep <= 1'b0;
    bus(1'b1, MASK_OFF, 32'h0);
    hit(16'h0010);
    `CHK("irq masked", 1'b0, irq)
    rdchk(STAT_OFF, 32'h1);
    bus(1'b1, FIELD_CTRL, 32'h0);
  endtask

  // Unit 2 output follows the route select.
  task automatic t_route();
    bus(1'b1, UNIT_STRIDE + FIELD_LO, 32'h20);
    bus(1'b1, UNIT_STRIDE, {28'h0, MODE_TOGGLE});
    hit(16'h0020);
    `CHK("line c1 pin", 1'b1, pc)
    `CHK("line c1 enable", 1'b1, pc_oe)
    `CHK("line b3 enable", 1'b0, pb_oe)
    bus(1'b1, ALT_OFF, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK("line b3 pin", 1'b1, pb)
    `CHK("line b3 routed", 1'b1, pb_oe)
    `CHK("line c1 released", 1'b0, pc_oe)
    bus(1'b1, UNIT_STRIDE, 32'h0);
    bus(1'b1, ALT_OFF, 32'h0);
  endtask

  // Special event on unit 2: timer clear, converter start, no overflow.
  task automatic t_special();
    bus(1'b0, STAT_OFF, 32'h0);
    adc_en <= 1'b1;
    s0 = starts;
    bus(1'b1, UNIT_STRIDE + FIELD_LO, 32'h40);
    bus(1'b1, UNIT_STRIDE, {28'h0, MODE_SPECIAL});
    hit(16'h0040);
    `CHK("clear request", 1'b1, clr)
    `CHK("count held", 16'h0040, cnt)
    `CHK("pins released", 2'b00, {pc_oe, pb_oe})
    `CHK("one start", 1, starts - s0)
    run <= 1'b1;
    repeat (8) @(posedge mclk);
    run <= 1'b0;
    `CHK("count cleared", 1'b1, cnt < 16'h0004)
    `CHK("no overflow", 1'b0, ovf)
    `CHK("start pulse once", 1, starts - s0)
    rdchk(STAT_OFF, 32'h2);
    bus(1'b1, UNIT_STRIDE, 32'h0);
  endtask

  // A rewritten match value withdraws the pending clear; unit 1 starts nothing.
  task automatic t_cancel();
    s0 = starts;
    bus(1'b1, FIELD_LO, 32'h80);
    bus(1'b1, FIELD_CTRL, {28'h0, MODE_SPECIAL});
    hit(16'h0080);
    `CHK("clear pending", 1'b1, clr)
    bus(1'b1, FIELD_LO, 32'h81);
    repeat (3) @(posedge mclk);
    `CHK("clear withdrawn", 1'b0, clr)
    run <= 1'b1;
    repeat (4) @(posedge mclk);
    run <= 1'b0;
    @(posedge mclk);
    `CHK("count kept", 16'h0081, cnt)
    `CHK("unit1 no start", 0, starts - s0)
    bus(1'b1, FIELD_CTRL, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Clock generator.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {rst, hsel, hwrite, run, load, adc_en, sleep} = 7'h40;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ld_val = 16'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_pin();
    t_swint();
    t_route();
    t_special();
    t_cancel();
    report_and_stop();
  end
endmodule // tb_timer_compare_match_unit
